// File: include/pos_framer_consts.svh
/*
 constants of the position and emergency framer: identifiers, lengths,
 object dictionary indices, codes and timing. assumes a 200 MHz clock.
*/
`ifndef POS_FRAMER_CONSTS_SVH
`define POS_FRAMER_CONSTS_SVH
// frame identifiers (node number is added) and lengths
`define ID_BOOT      11'h700
`define ID_EMCY      11'h080
`define ID_PDO1      11'h180
`define ID_PDO2      11'h280
`define DLC_BOOT     4'h1
`define DLC_EMCY     4'h8
`define DLC_PDO      4'h6
`define FRAME_W      79
`define FIFO_DEPTH   16
// object dictionary indices and subindices
`define OD_ERR_REG   16'h1001
`define OD_STATUS    16'h1002
`define OD_STORE     16'h1010
`define OD_PDO1_COMM 16'h1800
`define OD_RESOL     16'h6005
`define OD_CYCLE     16'h6200
`define SUB_ZERO     8'h00
`define SUB_ONE      8'h01
`define SUB_RES_SPD  8'h02
`define SUB_TTYPE    8'h02
`define SUB_EVTMR    8'h05
`define SAVE_SIG     32'h65766173
// transmission types and reset values
`define TT_PDO1_RST  8'hFF
`define TT_PDO2_RST  8'h01
`define TT_TIMER_MIN 8'hFE
`define EVT1_RST     16'h000A
`define EVT2_RST     16'h0000
`define SPD_RES_MMS  32'h00000001
`define POS_RES_UM   1
// emergency error codes
`define EC_NONE      16'h0000
`define EC_SUPPLY    16'h3110
`define EC_TEMP      16'h4000
`define EC_HW        16'h5000
`define EC_SW        16'h6000
`define EC_DATASET   16'h6300
`define EC_COMM      16'h8100
`define EC_GUARD     16'h8130
`define EC_PROFILE   16'hFF00
// error register bits
`define ER_DATASET   8'h01
`define ER_SUPPLY    8'h04
`define ER_TEMP      8'h08
`define ER_COMM      8'h10
`define ER_PROFILE   8'h20
`define ER_HW        8'h80
`define FAULT_POS    32'hFFFFFFFF
// timing
`define CLK_PERIOD_NS 5
`define MS_IN_NS      1000000
`define CYC_PER_MS    (`MS_IN_NS / `CLK_PERIOD_NS)
`define BOOT_MS       10
`endif

// File: include/posframer_pkg.sv
/*
 types of the position and emergency framer.
 assumes nothing of its surroundings.
*/
package posframer_pkg;
    typedef enum logic [1:0] {
        ST_BOOT  = 2'b00,
        ST_PREOP = 2'b01,
        ST_OPER  = 2'b10
    } nodeState_t;
    typedef enum logic [1:0] {
        FR_BOOT = 2'b00,
        FR_EMCY = 2'b01,
        FR_PDO1 = 2'b10,
        FR_PDO2 = 2'b11
    } frameKind_t;
endpackage

// File: src/frame_fifo.sv
/*
 first-word-fall-through frame queue with a registered read port.
 assumes DEPTH is a power of two and one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pos_framer_consts.svh"
module frame_fifo #(
    parameter int WIDTH = `FRAME_W,
    parameter int DEPTH = `FIFO_DEPTH
)(
    // clock and reset
    input  wire logic             clock,
    input  wire logic             reset,
    // fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_q;
    logic [AW-1:0]    rdPtr_q;
    logic [AW:0]      count_q;
    logic             outValid_q;
    logic [WIDTH-1:0] outData_q;
    logic             push;
    logic             load;

    assign inReady  = count_q != (AW+1)'(DEPTH);
    assign push     = inValid && inReady;
    // refill the output register when it is empty or being taken
    assign load     = (count_q != '0) && (!outValid_q || outReady);
    assign outValid = outValid_q;
    assign outData  = outData_q;

    always_ff @(posedge clock)
    begin
        if (push)
            mem[wrPtr_q] <= inData;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (push)
                wrPtr_q <= wrPtr_q + AW'(1);
            if (load)
                rdPtr_q <= rdPtr_q + AW'(1);
            if (push && !load)
                count_q <= count_q + (AW+1)'(1);
            else if (load && !push)
                count_q <= count_q - (AW+1)'(1);
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            outValid_q <= 1'b0;
            outData_q  <= '0;
        end
        else if (load)
        begin
            outValid_q <= 1'b1;
            outData_q  <= mem[rdPtr_q];
        end
        else if (outReady)
            outValid_q <= 1'b0;
    end
endmodule
`default_nettype wire

// File: src/position_pdo_emergency_framer.sv
/*
 framer of boot-up, emergency and position/speed process-data frames,
 with a small object dictionary port. assumes all inputs come from logic
 on the same clock and the CAN controller drains the frame queue.
*/
// What this block does
// - position 32-bit, speed 16-bit in frames
// - first frame id 180h+node, six bytes
// - speed one count per mm/s
// - resolutions readable at index 6005
// - emergency on every error status change
// - emergency id 80h+node, eight bytes
// - code, error byte, status word, zero byte
// - codes 0000h, 5000h hardware, 6300h data set
// - further codes supply, temperature, software, bus
// - error byte bits per fault class
// - magnet one in frame one, two in two
// - first frame defaults to timer type FFh
// - second frame defaults to sync type 01h
// - transmission type and event timer writable
// - save signature at 1010.1 stores configuration
// - no frame before boot time, boot-up message first
// - fault gives all-ones position and emergency
// - missing magnet, zone, element failure are faults
// - cycle time sets first event timer only
`timescale 1ns/10ps
`default_nettype none
`include "pos_framer_consts.svh"
module position_pdo_emergency_framer
    import posframer_pkg::*;
#(
    parameter int CYC_PER_MS = `CYC_PER_MS,
    parameter int BOOT_MS    = `BOOT_MS,
    parameter int POS_RES_UM = `POS_RES_UM
)(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        reset,
    // node and network
    input  wire logic [6:0]  nodeId,
    input  wire logic        startCmd,
    input  wire logic        syncRx,
    // measurement samples
    input  wire logic        sampleValid,
    input  wire logic [31:0] pos1,
    input  wire logic [15:0] spd1,
    input  wire logic [31:0] pos2,
    input  wire logic [15:0] spd2,
    // fault sources
    input  wire logic [1:0]  magnetMissing,
    input  wire logic [1:0]  magnetInZone,
    input  wire logic        elementFail,
    input  wire logic        hwErr,
    input  wire logic        datasetErr,
    input  wire logic        supplyErr,
    input  wire logic        tempErr,
    input  wire logic        swErr,
    input  wire logic        commErr,
    input  wire logic        guardErr,
    input  wire logic        profileErr,
    // object dictionary access
    input  wire logic        odWrite,
    input  wire logic        odRead,
    input  wire logic [15:0] odIndex,
    input  wire logic [7:0]  odSub,
    input  wire logic [31:0] odWdata,
    output logic             odAck,
    output logic             odAbort,
    output logic [31:0]      odRdata,
    // frame output
    output logic             txValid,
    input  wire logic        txReady,
    output logic [10:0]      txId,
    output logic [3:0]       txDlc,
    output logic [63:0]      txData,
    // status
    output logic             operational,
    output logic             saveReq
);
    nodeState_t  state_q;
    frameKind_t  enqKind;
    logic [31:0] msDiv_q;
    logic        msTick_q;
    logic [15:0] bootCnt_q;
    logic        bootPend_q;
    logic [1:0]  magFault;
    logic        hwFault;
    logic [15:0] errCode;
    logic [7:0]  errReg;
    logic [31:0] statusWord;
    logic [55:0] errStat;
    logic [55:0] prevErr_q;
    logic [55:0] emcyData_q;
    logic        emcyPend_q;
    logic        errChange;
    logic [31:0] pos_q [2];
    logic [15:0] spd_q [2];
    logic [7:0]  tt_q [2];
    logic [15:0] evt_q [2];
    logic [15:0] tmr_q [2];
    logic [7:0]  syncCnt_q [2];
    logic [1:0]  pdoPend_q;
    logic [1:0]  trig;
    logic [1:0]  accept;
    logic        enqValid;
    logic        enqReady;
    logic [10:0] enqId;
    logic [3:0]  enqDlc;
    logic [63:0] enqPay;
    logic        isSave;
    logic        rdHit;
    logic        wrHit;
    logic [31:0] rdVal;
    logic        odAck_q;
    logic        odAbort_q;
    logic [31:0] odRdata_q;
    logic        saveReq_q;
    logic        operational_q;

    assign odAck       = odAck_q;
    assign odAbort     = odAbort_q;
    assign odRdata     = odRdata_q;
    assign saveReq     = saveReq_q;
    assign operational = operational_q;

    // status pin straight from a flop; lags the state by one cycle
    always_ff @(posedge clock)
    begin
        operational_q <= !reset && state_q == ST_OPER;
    end

    // millisecond enable
    always_ff @(posedge clock)
    begin
        if (reset || msDiv_q == 32'(CYC_PER_MS - 1))
            msDiv_q <= '0;
        else
            msDiv_q <= msDiv_q + 32'h1;
        msTick_q <= !reset && msDiv_q == 32'(CYC_PER_MS - 1);
    end

    // power-up, boot-up message, start command
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            state_q    <= ST_BOOT;
            bootCnt_q  <= '0;
            bootPend_q <= 1'b0;
        end
        else
        begin
            if (accept == 2'b00 && enqValid && enqReady && enqKind == FR_BOOT)
                bootPend_q <= 1'b0;
            case (state_q)
                ST_BOOT:
                    if (msTick_q)
                    begin
                        bootCnt_q <= bootCnt_q + 16'h1;
                        if (bootCnt_q == 16'(BOOT_MS - 1))
                        begin
                            state_q    <= ST_PREOP;
                            bootPend_q <= 1'b1;
                        end
                    end
                ST_PREOP:
                    if (startCmd)
                        state_q <= ST_OPER;
                ST_OPER:
                    state_q <= ST_OPER;
                default:
                    state_q <= ST_BOOT;
            endcase
        end
    end

    // fault classification
    assign magFault = magnetMissing | magnetInZone | {2{elementFail}};
    assign hwFault  = hwErr | (|magFault);
    assign errReg   = (datasetErr ? `ER_DATASET : 8'h00)
                    | (supplyErr ? `ER_SUPPLY : 8'h00)
                    | (tempErr ? `ER_TEMP : 8'h00)
                    | (commErr || guardErr ? `ER_COMM : 8'h00)
                    | (profileErr || swErr ? `ER_PROFILE : 8'h00)
                    | (hwFault ? `ER_HW : 8'h00);
    assign errCode  = hwFault ? `EC_HW :
                      datasetErr ? `EC_DATASET :
                      supplyErr ? `EC_SUPPLY :
                      tempErr ? `EC_TEMP :
                      swErr ? `EC_SW :
                      guardErr ? `EC_GUARD :
                      commErr ? `EC_COMM :
                      profileErr ? `EC_PROFILE : `EC_NONE;
    assign statusWord = {27'h0, elementFail, magnetInZone, magnetMissing};
    assign errStat    = {statusWord, errReg, errCode};
    assign errChange  = state_q != ST_BOOT && errStat != prevErr_q;

    // emergency on any change, including back to no error
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            prevErr_q  <= '0;
            emcyData_q <= '0;
            emcyPend_q <= 1'b0;
        end
        else if (errChange)
        begin
            prevErr_q  <= errStat;
            emcyData_q <= errStat;
            emcyPend_q <= 1'b1;
        end
        else if (enqValid && enqReady && enqKind == FR_EMCY)
            emcyPend_q <= 1'b0;
    end

    // latest measurement per magnet
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            pos_q <= '{default: '0};
            spd_q <= '{default: '0};
        end
        else if (sampleValid)
        begin
            pos_q[0] <= pos1;
            spd_q[0] <= spd1;
            pos_q[1] <= pos2;
            spd_q[1] <= spd2;
        end
    end

    // per process-data object: parameters and triggering
    for (genvar i = 0; i < 2; i++)
    begin : g_pdo
        localparam logic [15:0] COMM_IDX = `OD_PDO1_COMM + 16'(i);
        logic timed;
        assign timed = tt_q[i] >= `TT_TIMER_MIN;
        assign trig[i] = timed
            ? msTick_q && evt_q[i] != '0 && {1'b0, tmr_q[i]} + 17'h1 >= {1'b0, evt_q[i]}
            : syncRx && {1'b0, syncCnt_q[i]} + 9'h1 >= {1'b0, tt_q[i]};
        assign accept[i] = enqValid && enqReady && enqKind == (i == 0 ? FR_PDO1 : FR_PDO2);

        always_ff @(posedge clock)
        begin
            if (reset)
            begin
                tt_q[i]  <= i == 0 ? `TT_PDO1_RST : `TT_PDO2_RST;
                evt_q[i] <= i == 0 ? `EVT1_RST : `EVT2_RST;
            end
            else if (odWrite && odIndex == COMM_IDX && odSub == `SUB_TTYPE)
                tt_q[i] <= odWdata[7:0];
            else if (odWrite && ((odIndex == COMM_IDX && odSub == `SUB_EVTMR)
                     || (i == 0 && odIndex == `OD_CYCLE && odSub == `SUB_ZERO)))
                evt_q[i] <= odWdata[15:0];
        end

        // counters clear outside operation so no process-data frame leaks before start
        always_ff @(posedge clock)
        begin
            if (reset || state_q != ST_OPER)
            begin
                tmr_q[i]     <= '0;
                syncCnt_q[i] <= '0;
                pdoPend_q[i] <= 1'b0;
            end
            else
            begin
                pdoPend_q[i] <= trig[i] || (pdoPend_q[i] && !accept[i]);
                if (timed && msTick_q)
                    tmr_q[i] <= trig[i] ? 16'h0 : tmr_q[i] + 16'h1;
                if (!timed && syncRx)
                    syncCnt_q[i] <= trig[i] ? 8'h0 : syncCnt_q[i] + 8'h1;
            end
        end
    end

    // frame selection: boot-up, then emergency, then process data
    always_comb
    begin
        enqValid = 1'b1;
        enqKind  = FR_PDO2;
        if (bootPend_q)
            enqKind = FR_BOOT;
        else if (emcyPend_q)
            enqKind = FR_EMCY;
        else if (pdoPend_q[0])
            enqKind = FR_PDO1;
        else if (!pdoPend_q[1])
            enqValid = 1'b0;
        case (enqKind)
            FR_BOOT:
            begin
                enqId  = `ID_BOOT + {4'h0, nodeId};
                enqDlc = `DLC_BOOT;
                enqPay = '0;
            end
            FR_EMCY:
            begin
                enqId  = `ID_EMCY + {4'h0, nodeId};
                enqDlc = `DLC_EMCY;
                enqPay = {8'h00, emcyData_q};
            end
            FR_PDO1:
            begin
                enqId  = `ID_PDO1 + {4'h0, nodeId};
                enqDlc = `DLC_PDO;
                enqPay = {16'h0, spd_q[0],
                          magFault[0] ? `FAULT_POS : pos_q[0]};
            end
            default:
            begin
                enqId  = `ID_PDO2 + {4'h0, nodeId};
                enqDlc = `DLC_PDO;
                enqPay = {16'h0, spd_q[1], magFault[1] ? `FAULT_POS : pos_q[1]};
            end
        endcase
    end

    // queue absorbs bus back-pressure; a full queue holds frames pending
    frame_fifo #(
        .WIDTH (`FRAME_W),
        .DEPTH (`FIFO_DEPTH)
    ) u_queue (
        .clock    (clock),
        .reset    (reset),
        .inValid  (enqValid),
        .inReady  (enqReady),
        .inData   ({enqId, enqDlc, enqPay}),
        .outValid (txValid),
        .outReady (txReady),
        .outData  ({txId, txDlc, txData})
    );

    // object dictionary decode
    assign isSave = odIndex == `OD_STORE && odSub == `SUB_ONE;
    assign wrHit  = (isSave && odWdata == `SAVE_SIG)
                  || (odIndex[15:1] == `OD_PDO1_COMM >> 1
                      && (odSub == `SUB_TTYPE || odSub == `SUB_EVTMR))
                  || (odIndex == `OD_CYCLE && odSub == `SUB_ZERO);
    always_comb
    begin
        rdHit = 1'b1;
        rdVal = '0;
        if (odIndex == `OD_ERR_REG && odSub == `SUB_ZERO)
            rdVal = {24'h0, errReg};
        else if (odIndex == `OD_STATUS && odSub == `SUB_ZERO)
            rdVal = statusWord;
        else if (odIndex == `OD_RESOL && odSub == `SUB_ONE)
            rdVal = 32'(POS_RES_UM);
        else if (odIndex == `OD_RESOL && odSub == `SUB_RES_SPD)
            rdVal = `SPD_RES_MMS;
        else if (odIndex == `OD_CYCLE && odSub == `SUB_ZERO)
            rdVal = {16'h0, evt_q[0]};
        else if (odIndex[15:1] == `OD_PDO1_COMM >> 1 && odSub == `SUB_TTYPE)
            rdVal = {24'h0, tt_q[odIndex[0]]};
        else if (odIndex[15:1] == `OD_PDO1_COMM >> 1 && odSub == `SUB_EVTMR)
            rdVal = {16'h0, evt_q[odIndex[0]]};
        else
            rdHit = 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            odAck_q   <= 1'b0;
            odAbort_q <= 1'b0;
            odRdata_q <= '0;
            saveReq_q <= 1'b0;
        end
        else
        begin
            odAck_q   <= (odWrite && wrHit) || (odRead && !odWrite && rdHit);
            odAbort_q <= (odWrite && !wrHit) || (odRead && !odWrite && !rdHit);
            saveReq_q <= odWrite && isSave && odWdata == `SAVE_SIG;
            if (odRead && !odWrite && rdHit)
                odRdata_q <= rdVal;
        end
    end

    a_pdo1_frame: assert property (@(posedge clock) disable iff (reset)
        enqValid && enqKind == FR_PDO1 |-> enqDlc == 4'h6 && enqId == 11'h180 + {4'h0, nodeId})
        else $error("first process frame id or length wrong");
    a_fault_pos: assert property (@(posedge clock) disable iff (reset)
        enqValid && enqKind == FR_PDO1 && magFault[0] |-> enqPay[31:0] == 32'hFFFFFFFF)
        else $error("faulted position not all ones");
    a_emcy_frame: assert property (@(posedge clock) disable iff (reset)
        enqValid && enqKind == FR_EMCY |-> enqDlc == 4'h8 && enqPay[63:56] == 8'h00)
        else $error("emergency length or last byte wrong");
    a_boot_quiet: assert property (@(posedge clock) disable iff (reset)
        state_q == ST_BOOT |-> !enqValid)
        else $error("frame queued before boot time");
    a_hw_code: assert property (@(posedge clock) disable iff (reset)
        (errReg == 8'h00 |-> errCode == 16'h0000) and (errReg[7] |-> errCode == 16'h5000))
        else $error("error code disagrees with error byte");
    a_emcy_change: assert property (@(posedge clock) disable iff (reset)
        errChange |=> emcyPend_q && emcyData_q == $past(errStat))
        else $error("error change did not raise emergency");
    a_save_pulse: assert property (@(posedge clock) disable iff (reset)
        odWrite && isSave && odWdata == 32'h65766173 |=> saveReq_q && odAck_q)
        else $error("save signature not acted on");
    a_cycle_evt: assert property (@(posedge clock) disable iff (reset)
        odWrite && odIndex == 16'h6200 && odSub == 8'h00
        |=> evt_q[0] == $past(odWdata[15:0]) && $stable(evt_q[1]))
        else $error("cycle time did not reach first event timer only");
endmodule
`default_nettype wire

// File: dv/can_master_model.sv
/*
 network master stand-in: drains the frame queue and records every frame.
 assumes one clock and the framer's registered frame port.
*/
`timescale 1ns/10ps
`default_nettype none
module can_master_model (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        reset,
    // pacing
    input  wire logic        slow,
    // frame side
    input  wire logic        txValid,
    output logic             txReady,
    input  wire logic [10:0] txId,
    input  wire logic [3:0]  txDlc,
    input  wire logic [63:0] txData
);
    logic [2:0]  cnt;
    logic [78:0] rxq[$];
    // slow mode takes one frame in eight, so the queue backs up
    always @(posedge clock)
    begin
        cnt <= reset ? 3'h0 : cnt + 3'h1;
        txReady <= ~slow | (cnt == 3'h6);
        // kept as seen; the bench checks the record is still empty 10 cycles into boot time
        if (!reset && txValid && txReady)
            rxq.push_back({txId, txDlc, txData});
    end
endmodule
`default_nettype wire

// File: dv/position_pdo_emergency_framer_tb.sv
/*
 self-checking bench of the framer with a master model on the frame port.
 assumes short ms ticks (20 cycles) and a one-tick boot time.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pos_framer_consts.svh"
module position_pdo_emergency_framer_tb;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic [6:0]  nodeId = 7'h05;
    logic        startCmd = 1'b0, syncRx = 1'b0, sampleValid = 1'b0, slow = 1'b0;
    logic        odWrite = 1'b0, odRead = 1'b0;
    logic [31:0] pos1 = 32'h0, pos2 = 32'h0, odWdata = 32'h0, odRdata;
    logic [15:0] spd1 = 16'h0, spd2 = 16'h0, odIndex = 16'h0;
    logic [7:0]  odSub = 8'h0;
    logic [12:0] flt = 13'h0;
    logic        odAck, odAbort, txValid, txReady, operational, saveReq;
    logic [10:0] txId;
    logic [3:0]  txDlc;
    logic [63:0] txData;
    logic [78:0] f;
    int          n_fail = 0, checks = 0, cyc = 0;
    // error byte and code per fault input, in flt bit order
    logic [23:0] tbl[13] = '{24'h805000, 24'h805000, 24'h805000, 24'h805000, 24'h805000,
        24'h805000, 24'h016300, 24'h043110, 24'h084000, 24'h206000, 24'h108100,
        24'h108130, 24'h20FF00};

    position_pdo_emergency_framer #(.CYC_PER_MS(20), .BOOT_MS(1), .POS_RES_UM(1))
    i_position_pdo_emergency_framer (
        .clock, .reset, .nodeId, .startCmd, .syncRx, .sampleValid, .pos1, .spd1, .pos2, .spd2,
        .magnetMissing(flt[1:0]), .magnetInZone(flt[3:2]), .elementFail(flt[4]),
        .hwErr(flt[5]), .datasetErr(flt[6]), .supplyErr(flt[7]), .tempErr(flt[8]),
        .swErr(flt[9]), .commErr(flt[10]), .guardErr(flt[11]), .profileErr(flt[12]),
        .odWrite, .odRead, .odIndex, .odSub, .odWdata, .odAck, .odAbort, .odRdata,
        .txValid, .txReady, .txId, .txDlc, .txData, .operational, .saveReq);

    can_master_model i_can_master_model (.clock, .reset, .slow, .txValid, .txReady,
        .txId, .txDlc, .txData);

    initial forever #2.5 clock = ~clock;

    task automatic final_report();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // generous ceiling: the whole sequence needs well under 15000 cycles
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            final_report();
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one access, answer sampled the cycle after it is taken
    task automatic odc(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                       input logic [31:0] wd, input logic xab, input logic [31:0] xrd,
                       input logic xsv);
        logic sv;
        @(posedge clock);
        odWrite <= wr;
        odRead <= ~wr;
        odIndex <= idx;
        odSub <= sub;
        odWdata <= wd;
        @(posedge clock);
        odWrite <= 1'b0;
        odRead <= 1'b0;
        #1;
        check(64'({odAbort, odAck}), 64'({xab, ~xab}));
        if (!wr && !xab)
            check(64'(odRdata), 64'(xrd));
        sv = saveReq;
        @(posedge clock);
        #1;
        check(64'(sv | saveReq), 64'(xsv));
    endtask

    // skips frames of other kinds until one with this identifier arrives
    task automatic get(input logic [10:0] id);
        int n;
        n = 0;
        f = '0;
        while (f[78:68] !== id && n < 3000)
        begin
            @(posedge clock);
            #1;
            n++;
            while (i_can_master_model.rxq.size() > 0 && f[78:68] !== id)
                f = i_can_master_model.rxq.pop_front();
        end
        check(64'(f[78:68]), 64'(id));
    endtask

    task automatic t_boot();
        repeat (10) @(posedge clock);
        #1;
        check(64'(i_can_master_model.rxq.size()), 64'h0);
        check(64'(operational), 64'h0);
        get(`ID_BOOT + 11'(nodeId));
        check(64'({f[67:64], f[7:0]}), 64'h100);
    endtask

    task automatic t_od();
        odc(0, `OD_RESOL, `SUB_RES_SPD, 0, 0, 32'h1, 0);
        odc(0, `OD_RESOL, `SUB_ONE, 0, 0, 32'h1, 0);
        odc(0, `OD_PDO1_COMM, `SUB_TTYPE, 0, 0, 32'hFF, 0);
        odc(0, 16'h1801, `SUB_TTYPE, 0, 0, 32'h01, 0);
        odc(0, `OD_ERR_REG, `SUB_ZERO, 0, 0, 32'h0, 0);
        odc(1, `OD_ERR_REG, `SUB_ZERO, 32'h1, 1, 0, 0);
        odc(0, 16'h2000, `SUB_ZERO, 0, 1, 0, 0);
        odc(1, `OD_STORE, `SUB_ONE, 32'h00000000, 1, 0, 0);
        odc(1, `OD_STORE, `SUB_ONE, `SAVE_SIG, 0, 0, 1);
        odc(1, `OD_CYCLE, `SUB_ZERO, 32'h14, 0, 0, 0);
        odc(0, `OD_PDO1_COMM, `SUB_EVTMR, 0, 0, 32'h14, 0);
        odc(0, 16'h1801, `SUB_EVTMR, 0, 0, 32'h0, 0);
    endtask

    task automatic t_pdo();
        @(posedge clock);
        pos1 <= 32'h12345678;
        spd1 <= 16'hBEEF;
        pos2 <= 32'h0A0B0C0D;
        spd2 <= 16'h4321;
        sampleValid <= 1'b1;
        @(posedge clock);
        sampleValid <= 1'b0;
        startCmd <= 1'b1;
        @(posedge clock);
        startCmd <= 1'b0;
        repeat (2) @(posedge clock);
        check(64'(operational), 64'h1);
        get(`ID_PDO1 + 11'(nodeId));
        check(64'({f[67:64], f[47:0]}), {12'h0, 4'h6, 48'hBEEF12345678});
        @(posedge clock);
        syncRx <= 1'b1;
        @(posedge clock);
        syncRx <= 1'b0;
        get(`ID_PDO2 + 11'(nodeId));
        check(64'(f[47:0]), 64'h43210A0B0C0D);
    endtask

    task automatic t_cfg();
        odc(1, 16'h1801, `SUB_TTYPE, 32'hFF, 0, 0, 0);
        odc(1, 16'h1801, `SUB_EVTMR, 32'h0A, 0, 0, 0);
        odc(0, 16'h1801, `SUB_EVTMR, 0, 0, 32'h0A, 0);
        get(`ID_PDO2 + 11'(nodeId));
    endtask

    task automatic t_fault();
        slow <= 1'b1;
        for (int i = 0; i < 13; i++)
        begin
            @(posedge clock);
            flt <= 13'h1 << i;
            get(`ID_EMCY + 11'(nodeId));
            check(64'(f[67:64]), 64'h8);
            check(f[63:0], {8'h0, 27'h0, 5'((13'h1 << i) & 13'h1F), tbl[i]});
            if (i == 0)
            begin
                get(`ID_PDO1 + 11'(nodeId));
                check(64'(f[31:0]), 64'hFFFFFFFF);
            end
            @(posedge clock);
            flt <= 13'h0;
            get(`ID_EMCY + 11'(nodeId));
            check(f[63:0], 64'h0);
        end
        slow <= 1'b0;
    endtask

    initial
    begin
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        t_boot();
        t_od();
        t_pdo();
        t_cfg();
        t_fault();
        final_report();
    end
endmodule
`default_nettype wire
